/* hpp_pkg.sv */
// Purpose: shared types and constants for the handshake parallel port
// Assumes: single system clock, all pins synchronised inside the port
// Notes:   control words are told apart by their low bits, not by an address
package hpp_pkg;

  // control word tags in the low bits
  localparam logic [3:0] HPP_CW_MODE_TAG = 4'hf;
  localparam logic [3:0] HPP_CW_INT_TAG  = 4'h7;
  localparam int         HPP_CW_TAG_LSB  = 0;
  localparam int         HPP_CW_MODE_LSB = 6;
  localparam int         HPP_CW_IE_BIT   = 7;
  localparam int         HPP_CW_AND_BIT  = 6;
  localparam int         HPP_CW_POL_BIT  = 5;
  localparam int         HPP_CW_MASK_BIT = 4;
  localparam int         HPP_CW_VEC_FLAG = 0;

  // reset values
  localparam logic [7:0] HPP_MASK_RESET  = 8'hff;
  localparam logic [7:0] HPP_OUT_RESET   = 8'h00;
  localparam logic [7:0] HPP_DIR_RESET   = 8'hff;
  localparam logic [6:0] HPP_VEC_RESET   = 7'h00;
  localparam logic [7:0] HPP_ALL_LINES   = 8'hff;
  localparam logic [7:0] HPP_NO_LINES    = 8'h00;

  // input buffer depth per port
  localparam logic [1:0] HPP_BUF_DEPTH   = 2'h2;

  typedef enum logic [1:0] {
    HPP_MODE_OUT   = 2'h0,
    HPP_MODE_IN    = 2'h1,
    HPP_MODE_BIDIR = 2'h2,
    HPP_MODE_BIT   = 2'h3
  } hpp_mode_t;

  // bus cycle tracker, gray along idle-fetch-seen and idle-io-idle
  typedef enum logic [1:0] {
    HPP_BUS_IDLE  = 2'h0,
    HPP_BUS_FETCH = 2'h1,
    HPP_BUS_SEEN  = 2'h3,
    HPP_BUS_IO    = 2'h2
  } hpp_bus_t;

  typedef struct packed {
    logic       ie_in;
    logic [7:0] pb;
    logic [7:0] pa;
    logic [7:0] dbus;
    logic       ce_n;
    logic       io_request_n_n;
    logic       rd_n;
    logic       m1_n;
    logic       sel_b;
    logic       cmd;
    logic       stb_a_n;
    logic       stb_b_n;
  } hpp_pins_t;

  typedef struct packed {
    hpp_mode_t       mode;
    logic [7:0]      out_reg;
    logic [7:0]      dir;
    logic [7:0]      mask;
    logic            ie;
    logic            and_op;
    logic            pol_high;
    logic            pending;
    logic            ready;
    logic [6:0]      vec;
    logic            exp_dir;
    logic            exp_mask;
    logic            mon_prev;
    logic [1:0][7:0] fifo;
    logic [1:0]      cnt;
    logic [7:0]      hold;
  } hpp_port_t;

  typedef struct packed {
    hpp_pins_t       s1;
    hpp_pins_t       s2;
    hpp_pins_t       s3;
    hpp_pins_t       f;
    logic [1:0]      stb_prev;
    hpp_bus_t        bus;
    logic            in_reset;
    logic            sel_b;
    logic            cmd;
    logic            was_write;
    logic            ack_valid;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    hpp_port_t [1:0] port;
  } hpp_state_t;

endpackage : hpp_pkg

/* hpp_port.sv */
// Purpose: two-port 8-bit parallel port with ready/strobe handshakes
// Assumes: 10 MHz clk_sys; every pin is asynchronous and synchronised here
// Notes:   ready moves on clk_sys edges only; pin delays add four cycles
//
// Overview of operation
// RULE1: reset masks all lines, clears enables and outputs, keeps vectors
// RULE2: in reset port lines float, both ready low, input mode selected
// RULE3: fetch pulse without read or io request resets after it ends
// RULE4: after reset, stay there until any control word arrives
// RULE5: control word with bit0 low loads vector; acknowledge returns it with bit0 zero
// RULE6: low nibble 1111 sets mode from bits 7:6
// RULE7: only port A may be bidirectional
// RULE8: output mode drives output register; register readable and rewritable anytime
// RULE9: output mode write raises ready; strobe rise drops it and requests interrupt
// RULE10: input mode read raises ready; strobe loads data, rise drops ready, interrupts
// RULE11: bidirectional: A pair handles output, B pair input; A drives only during strobe
// RULE12: bit mode needs direction word next; one means input, zero output
// RULE13: bit mode ignores strobe, ready low; reads mix inputs and output bits
// RULE14: interrupt word bit7 sets or clears the port interrupt enable
// RULE15: pending request reaches interrupt line once enable is set
// RULE16: interrupt word with bit4 set clears pending request in any mode
// RULE17: bit mode monitor: bit6 one means AND, zero means OR
// RULE18: bit5 selects monitored active level, one high, zero low
// RULE19: bit4 set means mask word follows; only zero mask bits monitored
// RULE20: output write raises ready on a later clock edge; drops on clock edges
// RULE21: write with ready high forces ready low, high again after request ends
// RULE22: outside reset the output register may be loaded before output mode
// RULE23: processor selects port and command or data with the two select pins
// RULE24: chip select plus io request reads with read low, else writes
// RULE25: interrupt control word tagged by low nibble 0111
// RULE26: word after bit mode or mask request is data, not decoded
`timescale 1ns/100ps
`default_nettype none

module hpp_port
  import hpp_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // processor bus
  input  wire logic       chip_enable_n,
  input  wire logic       io_request_n,
  input  wire logic       read_n,
  input  wire logic       opcode_fetch_cycle_n,
  input  wire logic       port_b_select,
  input  wire logic       control_select,
  input  wire logic [7:0] cpu_data_in,
  output var  logic [7:0] cpu_data_out,
  output var  logic       cpu_data_oe,
  // interrupt and priority chain
  input  wire logic       priority_enable_in,
  output var  logic       priority_enable_out,
  output var  logic       int_request_out,
  output var  logic       int_request_oe,
  // port A
  input  wire logic [7:0] port_a_in,
  output var  logic [7:0] port_a_out,
  output var  logic [7:0] port_a_oe,
  input  wire logic       port_a_strobe_n,
  output var  logic       port_a_ready,
  // port B
  input  wire logic [7:0] port_b_in,
  output var  logic [7:0] port_b_out,
  output var  logic [7:0] port_b_oe,
  input  wire logic       port_b_strobe_n,
  output var  logic       port_b_ready
);
  import hpp_pkg::*;

  hpp_state_t st;
  hpp_state_t next_st;
  hpp_pins_t  pins_now;

  assign pins_now = hpp_pins_t'({priority_enable_in, port_b_in, port_a_in, cpu_data_in,
                                 chip_enable_n, io_request_n, read_n, opcode_fetch_cycle_n,
                                 port_b_select, control_select, port_a_strobe_n, port_b_strobe_n});

  // port state after a reset; vector is carried over
  function automatic hpp_port_t hpp_port_clear(input hpp_port_t p);
    hpp_port_t r;
    r          = '0;
    r.mask     = HPP_MASK_RESET;    // RULE1
    r.out_reg  = HPP_OUT_RESET;     // RULE1
    r.dir      = HPP_DIR_RESET;
    r.mode     = HPP_MODE_IN;       // RULE2
    r.vec      = p.vec;             // RULE1
    return r;
  endfunction : hpp_port_clear

  function automatic hpp_state_t hpp_state_init();
    hpp_state_t s;
    s          = '0;
    s.s1       = hpp_pins_t'('1);
    s.s2       = hpp_pins_t'('1);
    s.s3       = hpp_pins_t'('1);
    s.f        = hpp_pins_t'('1);
    s.stb_prev = 2'h3;
    s.bus      = HPP_BUS_IDLE;
    s.in_reset = 1'b1;
    for (int k = 0; k < 2; k++) begin
      s.port[k]     = hpp_port_clear(s.port[k]);
      s.port[k].vec = HPP_VEC_RESET;
    end
    return s;
  endfunction : hpp_state_init

  // value a processor read sees
  function automatic logic [7:0] hpp_read_value(input hpp_port_t p, input logic [7:0] lines);
    logic [7:0] r;
    r = HPP_NO_LINES;
    unique case (p.mode)
      HPP_MODE_OUT:                r = p.out_reg;                                  // RULE8
      HPP_MODE_IN, HPP_MODE_BIDIR: r = p.fifo[0];
      HPP_MODE_BIT:                r = (lines & p.dir) | (p.out_reg & ~p.dir);    // RULE13
    endcase
    return r;
  endfunction : hpp_read_value

  // line drivers per mode
  function automatic logic [7:0] hpp_line_oe(input hpp_port_t p, input logic stb_low);
    logic [7:0] r;
    r = HPP_NO_LINES;
    unique case (p.mode)
      HPP_MODE_OUT:   r = HPP_ALL_LINES;                          // RULE8
      HPP_MODE_IN:    r = HPP_NO_LINES;                           // RULE2
      HPP_MODE_BIDIR: r = stb_low ? HPP_ALL_LINES : HPP_NO_LINES; // RULE11
      HPP_MODE_BIT:   r = ~p.dir;                                 // RULE12
    endcase
    return r;
  endfunction : hpp_line_oe

  // bit mode monitor equation
  function automatic logic hpp_monitor(input hpp_port_t p, input logic [7:0] lines);
    logic [7:0] act;
    act = p.pol_high ? lines : ~lines;                            // RULE18
    if (p.and_op) begin
      return ((act | p.mask) == HPP_ALL_LINES) && (p.mask != HPP_ALL_LINES); // RULE17 RULE19
    end
    return |(act & ~p.mask);                                      // RULE17 RULE19
  endfunction : hpp_monitor

  function automatic logic hpp_has_room(input hpp_port_t p);
    return p.cnt != HPP_BUS_DEPTH_FIX(p.cnt);
  endfunction : hpp_has_room

  function automatic logic [1:0] HPP_BUS_DEPTH_FIX(input logic [1:0] c);
    return (c == HPP_BUF_DEPTH) ? c : HPP_BUF_DEPTH;
  endfunction : HPP_BUS_DEPTH_FIX

  // two-entry input buffer; a full buffer refuses the word
  function automatic hpp_port_t hpp_fifo_step(input hpp_port_t p, input logic push,
                                              input logic pop, input logic [7:0] d);
    hpp_port_t r;
    r = p;
    if (pop && r.cnt != 2'h0) begin
      if (r.cnt == HPP_BUF_DEPTH) begin
        r.fifo[0] = r.fifo[1];
      end
      r.cnt = r.cnt - 2'h1;
    end
    if (push && r.cnt != HPP_BUF_DEPTH) begin
      r.fifo[r.cnt[0]] = d;
      r.cnt            = r.cnt + 2'h1;
    end
    return r;
  endfunction : hpp_fifo_step

  logic       a_bidir;
  logic       int_any;
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] rise;
  logic [1:0] low;
  logic [7:0] lines [2];
  logic       io_start;
  logic       io_end;
  logic       do_reset;
  logic       ack_take;
  logic       out_chan;
  logic       in_owner;
  logic       in_buf;
  logic       in_ok;
  logic [7:0] w;

  assign a_bidir = st.port[0].mode == HPP_MODE_BIDIR;
  assign int_any = (st.port[0].pending & st.port[0].ie) | (st.port[1].pending & st.port[1].ie); // RULE14 RULE15
  assign lines[0] = st.f.pa;
  assign lines[1] = st.f.pb;

  always_comb begin
    next_st    = st;
    io_start   = 1'b0;
    io_end     = 1'b0;
    do_reset   = 1'b0;
    ack_take   = 1'b0;
    push       = 2'h0;
    pop        = 2'h0;
    w          = st.wdata;
    next_st.s1 = pins_now;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a bit changes only once the second and third stages agree
    next_st.f  = hpp_pins_t'((st.s2 & ~(st.s2 ^ st.s3)) | (st.f & (st.s2 ^ st.s3)));
    next_st.stb_prev = {st.f.stb_b_n, st.f.stb_a_n};
    rise = {st.f.stb_b_n, st.f.stb_a_n} & ~st.stb_prev;
    low  = ~{st.f.stb_b_n, st.f.stb_a_n};

    unique case (st.bus)
      HPP_BUS_IDLE: begin
        next_st.ack_valid = 1'b0;
        if (!st.f.m1_n) begin
          next_st.bus = HPP_BUS_FETCH;
        end else if (!st.f.ce_n && !st.f.io_request_n_n) begin  // RULE24
          next_st.bus       = HPP_BUS_IO;
          next_st.sel_b     = st.f.sel_b;               // RULE23
          next_st.cmd       = st.f.cmd;                 // RULE23
          next_st.was_write = st.f.rd_n;                // RULE24
          next_st.wdata     = st.f.dbus;
          io_start          = 1'b1;
        end
      end
      HPP_BUS_FETCH: begin
        if (!st.f.io_request_n_n) begin
          next_st.bus = HPP_BUS_SEEN;
          ack_take    = 1'b1;
        end else if (!st.f.rd_n) begin
          next_st.bus = HPP_BUS_SEEN;
        end else if (st.f.m1_n) begin
          next_st.bus = HPP_BUS_IDLE;
          do_reset    = 1'b1;                           // RULE3
        end
      end
      HPP_BUS_SEEN: begin
        if (st.f.m1_n) begin
          next_st.bus = HPP_BUS_IDLE;
        end
      end
      HPP_BUS_IO: begin
        if (st.was_write) begin
          next_st.wdata = st.f.dbus;
        end
        if (st.f.io_request_n_n || st.f.ce_n) begin
          next_st.bus = HPP_BUS_IDLE;
          io_end      = 1'b1;
        end
      end
    endcase

    // interrupt acknowledge: port A outranks port B
    if (ack_take && st.f.ie_in) begin
      for (int k = 0; k < 2; k++) begin
        if (st.port[k].pending && st.port[k].ie && !next_st.ack_valid) begin
          next_st.rdata           = {st.port[k].vec, 1'b0};  // RULE5
          next_st.ack_valid       = 1'b1;
          next_st.port[k].pending = 1'b0;
        end
      end
    end

    // which handshake pair serves the addressed port
    out_chan = (st.port[st.sel_b].mode == HPP_MODE_OUT) || (!st.sel_b && a_bidir);
    in_buf   = st.sel_b && !a_bidir;
    in_owner = st.sel_b || a_bidir;
    in_ok    = (st.port[st.sel_b].mode == HPP_MODE_IN) || (!st.sel_b && a_bidir);
    if (io_start) begin
      out_chan = (st.port[st.f.sel_b].mode == HPP_MODE_OUT) || (!st.f.sel_b && a_bidir);
      in_owner = st.f.sel_b || a_bidir;
      in_ok    = (st.port[st.f.sel_b].mode == HPP_MODE_IN) || (!st.f.sel_b && a_bidir);
      next_st.rdata = st.f.cmd ? HPP_NO_LINES : hpp_read_value(st.port[st.f.sel_b], lines[st.f.sel_b]);
      // data must not change under a ready peripheral
      if (!st.f.cmd && st.f.rd_n && out_chan && !st.in_reset) begin
        next_st.port[st.f.sel_b].ready = 1'b0;                      // RULE21
      end
      if (!st.f.cmd && !st.f.rd_n && in_ok) begin
        next_st.port[in_owner].ready = 1'b0;                        // RULE21
      end
    end

    if (io_end && st.was_write && st.cmd) begin
      next_st.in_reset = 1'b0;                                      // RULE4
      if (st.port[st.sel_b].exp_dir) begin
        next_st.port[st.sel_b].dir     = w;                         // RULE12 RULE26
        next_st.port[st.sel_b].exp_dir = 1'b0;
      end else if (st.port[st.sel_b].exp_mask) begin
        next_st.port[st.sel_b].mask     = w;                        // RULE19 RULE26
        next_st.port[st.sel_b].exp_mask = 1'b0;
      end else if (!w[HPP_CW_VEC_FLAG]) begin
        next_st.port[st.sel_b].vec = w[7:1];                        // RULE5
      end else if (w[HPP_CW_TAG_LSB +: 4] == HPP_CW_MODE_TAG) begin
        // port B keeps its mode when asked for bidirectional
        if (!(st.sel_b && w[HPP_CW_MODE_LSB +: 2] == HPP_MODE_BIDIR)) begin    // RULE7
          next_st.port[st.sel_b].mode     = hpp_mode_t'(w[HPP_CW_MODE_LSB +: 2]); // RULE6
          next_st.port[st.sel_b].ready    = 1'b0;
          next_st.port[st.sel_b].mon_prev = 1'b0;
          next_st.port[st.sel_b].exp_dir  = w[HPP_CW_MODE_LSB +: 2] == HPP_MODE_BIT; // RULE12
        end
      end else if (w[HPP_CW_TAG_LSB +: 4] == HPP_CW_INT_TAG) begin  // RULE25
        next_st.port[st.sel_b].ie       = w[HPP_CW_IE_BIT];         // RULE14
        next_st.port[st.sel_b].and_op   = w[HPP_CW_AND_BIT];        // RULE17
        next_st.port[st.sel_b].pol_high = w[HPP_CW_POL_BIT];        // RULE18
        if (w[HPP_CW_MASK_BIT]) begin
          next_st.port[st.sel_b].pending  = 1'b0;                   // RULE16
          next_st.port[st.sel_b].exp_mask = 1'b1;                   // RULE19
        end
      end
    end else if (io_end && st.was_write && !st.in_reset) begin
      next_st.port[st.sel_b].out_reg = w;                           // RULE8 RULE22
      if (out_chan) begin
        next_st.port[st.sel_b].ready = 1'b1;                        // RULE9 RULE20 RULE21
      end
    end else if (io_end && !st.was_write && !st.cmd && in_ok) begin
      pop[in_buf]                  = 1'b1;
      next_st.port[in_owner].ready = 1'b1;                          // RULE10 RULE21
    end

    // strobes; after bus decoding, so a strobe wins over a coincident io cycle end
    if (a_bidir) begin
      if (rise[0]) begin
        next_st.port[0].ready   = 1'b0;                             // RULE11
        next_st.port[0].pending = 1'b1;
      end
      if (low[1]) begin
        next_st.port[0].hold = st.f.pa;                             // RULE11
      end
      if (rise[1]) begin
        push[0]                 = 1'b1;
        next_st.port[1].ready   = 1'b0;
        next_st.port[1].pending = 1'b1;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (!(a_bidir && k == 0)) begin
        unique case (st.port[k].mode)
          HPP_MODE_OUT: begin
            if (rise[k]) begin
              next_st.port[k].ready   = 1'b0;                       // RULE9
              next_st.port[k].pending = 1'b1;
            end
          end
          HPP_MODE_IN: begin
            if (!(a_bidir && k == 1)) begin
              if (low[k]) begin
                next_st.port[k].hold = lines[k];                    // RULE10
              end
              if (rise[k]) begin
                push[k]                 = 1'b1;
                next_st.port[k].ready   = 1'b0;                     // RULE10
                next_st.port[k].pending = 1'b1;
              end
            end
          end
          HPP_MODE_BIT: begin
            // strobe unused; B ready belongs to the A input side
            if (!(a_bidir && k == 1)) begin
              next_st.port[k].ready = 1'b0;                         // RULE13
            end
            // no new request while a fetch pulse settles the chain
            if (st.f.m1_n) begin
              next_st.port[k].mon_prev = hpp_monitor(st.port[k], lines[k]);
              if (hpp_monitor(st.port[k], lines[k]) && !st.port[k].mon_prev) begin
                next_st.port[k].pending = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    for (int k = 0; k < 2; k++) begin
      next_st.port[k] = hpp_fifo_step(next_st.port[k], push[k], pop[k], st.port[k].hold);
    end

    if (do_reset) begin
      next_st.in_reset = 1'b1;                                      // RULE3 RULE4
      for (int k = 0; k < 2; k++) begin
        next_st.port[k] = hpp_port_clear(st.port[k]);               // RULE1 RULE2
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= hpp_state_init();                                       // RULE1 RULE2
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign cpu_data_out        = st.rdata;
  assign cpu_data_oe         = (st.bus == HPP_BUS_IO && !st.was_write && !st.f.rd_n && !st.f.ce_n)
                             || (st.bus == HPP_BUS_SEEN && st.ack_valid && !st.f.io_request_n_n); // RULE5 RULE24
  assign int_request_out     = 1'b0;
  assign int_request_oe      = int_any && st.f.ie_in;                                      // RULE15
  assign priority_enable_out = st.f.ie_in && !int_any;
  assign port_a_out          = st.port[0].out_reg;                                         // RULE8
  assign port_b_out          = st.port[1].out_reg;
  assign port_a_oe           = hpp_line_oe(st.port[0], low[0]);                            // RULE2 RULE11
  assign port_b_oe           = hpp_line_oe(st.port[1], 1'b0);                              // RULE2
  // a full buffer holds ready low so no strobed word is lost
  assign port_a_ready        = st.port[0].ready && (st.port[0].mode != HPP_MODE_IN || hpp_has_room(st.port[0]));
  assign port_b_ready        = st.port[1].ready && (a_bidir ? hpp_has_room(st.port[0])
                             : (st.port[1].mode != HPP_MODE_IN || hpp_has_room(st.port[1])));

endmodule : hpp_port

`default_nettype wire

/* hpp_port_properties.sv */
// Purpose: port-level checks for hpp_port
// Assumes: bus pins idle high outside bus cycles
// Notes:   bus effects allowed a few clocks after pins go quiet, for sync lag
`timescale 1ns/100ps
`default_nettype none
module hpp_props (
  // clock, reset and bus
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       io_request_n,
  input wire logic       opcode_fetch_cycle_n,
  input wire logic       cpu_data_oe,
  input wire logic       priority_enable_in,
  input wire logic       priority_enable_out,
  input wire logic       int_request_out,
  input wire logic       int_request_oe,
  // port pins
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic       port_a_strobe_n,
  input wire logic       port_a_ready,
  input wire logic       port_b_strobe_n,
  input wire logic       port_b_ready
);
  logic [3:0] quiet;
  // clocks since last bus pin activity, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !io_request_n || !opcode_fetch_cycle_n) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property ($fell(sys_rst) |-> !port_a_ready && !port_b_ready && port_a_oe == 8'h00)
    else $error("port not idle after reset");
  a_reset_out: assert property ($fell(sys_rst) |-> port_a_out == 8'h00 && !int_request_oe)
    else $error("outputs not cleared by reset");
  a_strobe_a_drop: assert property ($rose(port_a_strobe_n) && port_a_ready |-> ##[1:8] !port_a_ready)
    else $error("port a ready held after strobe");
  a_strobe_b_drop: assert property ($rose(port_b_strobe_n) && port_b_ready |-> ##[1:8] !port_b_ready)
    else $error("port b ready held after strobe");
  a_int_chain: assert property (int_request_oe |-> priority_enable_in && !int_request_out)
    else $error("interrupt line driven wrongly");
  a_chain_block: assert property (priority_enable_out |-> priority_enable_in && !int_request_oe)
    else $error("chain passed on while requesting");
  a_read_window: assert property (cpu_data_oe |-> quiet < 4'h8)
    else $error("data bus driven outside a bus cycle");
  a_out_by_bus: assert property (!$stable(port_a_out) |-> quiet < 4'hc)
    else $error("output register moved without a bus cycle");
  a_ready_by_bus: assert property ($rose(port_a_ready) || $rose(port_b_ready) |-> quiet < 4'hc)
    else $error("ready rose without a bus cycle");
  c_int: cover property (int_request_oe);
  c_ack: cover property (cpu_data_oe && !opcode_fetch_cycle_n);
  c_b_drop: cover property ($fell(port_b_ready));
endmodule : hpp_props
bind hpp_port hpp_props u_props (.*);
`default_nettype wire

/* hpp_periph.sv */
// Purpose: peripheral model for one port of hpp_port
// Assumes: strobes each new ready DLY+1 clocks later, low for four clocks
// Notes:   undriven lines show inverted data until strobe low so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module hpp_periph #(parameter logic [2:0] DLY = 3'h1) (
  // control
  input  wire logic       clk_sys,
  input  wire logic       en,
  input  wire logic [7:0] data,
  // port pins
  input  wire logic       ready,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  output var  logic       strobe_n = 1'b1,
  output var  logic [7:0] port_in,
  output var  logic [7:0] taken
);
  logic [2:0] cnt = 3'h0;
  logic       done = 1'b0;
  assign port_in = (port_oe & port_out) | (~port_oe & (strobe_n ? ~data : data));
  always @(posedge clk_sys) begin
    cnt <= cnt + 3'h1;
    if (!strobe_n && cnt == 3'h3) begin
      strobe_n <= 1'b1;
      taken    <= port_in;
      done     <= 1'b1;
    end else if (strobe_n && !ready) begin
      done <= 1'b0;
      cnt  <= 3'h0;
    end else if (strobe_n && (!en || done)) begin
      cnt <= 3'h0;
    end else if (strobe_n && cnt == DLY) begin
      strobe_n <= 1'b0;
      cnt      <= 3'h0;
    end
  end
endmodule : hpp_periph
`default_nettype wire

/* hpp_tb.sv */
// Purpose: self-checking bench for hpp_port
// Assumes: 8 idle clocks between bus cycles
// Notes:   chain input tied high; peripherals are models
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hpp_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       chip_enable_n = 1'b1;
  logic       io_request_n = 1'b1;
  logic       read_n = 1'b1;
  logic       opcode_fetch_cycle_n = 1'b1;
  logic       port_b_select = 1'b0;
  logic       control_select = 1'b0;
  logic [7:0] cpu_data_in = 8'h00;
  logic       en_a = 1'b0;
  logic       en_b = 1'b0;
  logic [7:0] pdat_b = 8'h00;
  logic [7:0] cpu_data_out, port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe, taken_a, q;
  logic       cpu_data_oe, priority_enable_out, int_request_out, int_request_oe, rm;
  logic       port_a_strobe_n, port_a_ready, port_b_strobe_n, port_b_ready;
  int         n_fail = 0;
  int         cmp_count = 0;
  hpp_port dut (.priority_enable_in(1'b1), .*);
  hpp_periph #(.DLY(3'h1)) u_pa (.clk_sys(clk_sys), .en(en_a), .data(8'h00), .ready(port_a_ready),
    .port_out(port_a_out), .port_oe(port_a_oe), .strobe_n(port_a_strobe_n), .port_in(port_a_in), .taken(taken_a));
  hpp_periph #(.DLY(3'h5)) u_pb (.clk_sys(clk_sys), .en(en_b), .data(pdat_b), .ready(port_b_ready),
    .port_out(port_b_out), .port_oe(port_b_oe), .strobe_n(port_b_strobe_n), .port_in(port_b_in), .taken());
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one bus cycle; ack drives fetch with io request and no chip select
  task automatic bus(input logic cmd, input logic sel, input logic rd, input logic ack, input logic [7:0] d);
    @(posedge clk_sys);
    chip_enable_n        <= ack;
    io_request_n         <= 1'b0;
    read_n               <= !rd;
    opcode_fetch_cycle_n <= !ack;
    port_b_select        <= sel;
    control_select       <= cmd;
    cpu_data_in          <= d;
    repeat (7) @(posedge clk_sys);
    q  = cpu_data_out;
    rm = port_a_ready;
    chip_enable_n        <= 1'b1;
    io_request_n         <= 1'b1;
    read_n               <= 1'b1;
    opcode_fetch_cycle_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : bus
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("rst_rdy", {port_a_ready, port_b_ready}, 8'h00);
    bus(0, 0, 0, 0, 8'h99);
    chk("held_out", port_a_out, 8'h00);
    bus(1, 0, 0, 0, 8'h42);
    bus(0, 0, 0, 0, 8'ha5);
    chk("pre_out", port_a_out, 8'ha5);
    chk("pre_oe", port_a_oe, 8'h00);
    bus(1, 0, 0, 0, 8'h0f);
    chk("out_oe", port_a_oe, 8'hff);
    bus(1, 0, 0, 0, 8'h07);
    en_a <= 1'b1;
    bus(0, 0, 0, 0, 8'h3c);
    repeat (30) @(posedge clk_sys);
    chk("taken_a", taken_a, 8'h3c);
    chk("int_off", int_request_oe, 8'h00);
    bus(1, 0, 0, 0, 8'h87);
    chk("int_on", int_request_oe, 8'h01);
    bus(0, 0, 0, 1, 8'h00);
    chk("vector", q, 8'h42);
    bus(0, 0, 0, 0, 8'h3d);
    repeat (30) @(posedge clk_sys);
    bus(1, 0, 0, 0, 8'h97);
    bus(1, 0, 0, 0, 8'hff);
    chk("int_clr", int_request_oe, 8'h00);
    bus(0, 0, 1, 0, 8'h00);
    chk("readback", q, 8'h3d);
    en_a <= 1'b0;
    bus(0, 0, 0, 0, 8'h11);
    bus(0, 0, 0, 0, 8'h22);
    chk("rdy_mid", rm, 8'h00);
    chk("rdy_back", port_a_ready, 8'h01);
    bus(1, 1, 0, 0, 8'h4f);
    pdat_b <= 8'h5a;
    en_b   <= 1'b1;
    bus(0, 1, 1, 0, 8'h00);
    repeat (30) @(posedge clk_sys);
    chk("rdy_b", port_b_ready, 8'h00);
    en_b <= 1'b0;
    bus(0, 1, 1, 0, 8'h00);
    chk("in_b", q, 8'h5a);
    bus(1, 1, 0, 0, 8'hcf);
    bus(1, 1, 0, 0, 8'hf0);
    chk("dir_b", port_b_oe, 8'h0f);
    bus(0, 1, 0, 0, 8'h0a);
    bus(0, 1, 1, 0, 8'h00);
    chk("mix_b", q, 8'haa);
    pdat_b <= 8'hda;
    bus(1, 1, 0, 0, 8'hb7);
    bus(1, 1, 0, 0, 8'h7f);
    chk("mon_idle", int_request_oe, 8'h00);
    pdat_b <= 8'h5a;
    repeat (10) @(posedge clk_sys);
    chk("mon_hit", int_request_oe, 8'h01);
    bus(1, 1, 0, 0, 8'h8f);
    chk("no_bidir_b", port_b_oe, 8'h0f);
    bus(1, 0, 0, 0, 8'h8f);
    chk("bidir_a", port_a_oe, 8'h00);
    opcode_fetch_cycle_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    opcode_fetch_cycle_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("frst_oe", port_b_oe, 8'h00);
    chk("frst_rdy", port_a_ready, 8'h00);
    bus(0, 1, 0, 0, 8'h77);
    chk("frst_out", port_b_out, 8'h00);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
